// *** hw/lbc_core.sv ***
// Purpose: local bus cycle sequencer with ready, lock, hold, prefetch
// Assumes: clk_sys is the double-frequency system clock
// Notes:   one clk_sys cycle per phase; inputs other than async done synchronous to clk_sys
//
// Behaviour
// [RL1] Command states repeat silently until ready; each repeat is a wait.
// [RL2] Command sampled every clock after status; held while postpone high.
// [RL3] Once command is active, postpone input is ignored for the cycle.
// [RL4] Postponing command leaves latch, transceiver, direction timing alone.
// [RL5] Status outputs go inactive after the status state.
// [RL6] Sync done sampled at end of phase 1 of each command state.
// [RL7] Async done sampled at command start, one clock to settle.
// [RL8] Outside logic keeps async done or its select inactive ending status.
// [RL9] Active-low selects gate each done input; either may end the cycle.
// [RL10] Outside logic disables sync done so async done surely ends cycle.
// [RL11] Direction low for reads, high before, during, between writes.
// [RL12] Write data driven from phase 2 of the status state.
// [RL13] Write data held one clock past the last command state.
// [RL14] Bus floats in phase 2 after write unless another write follows.
// [RL15] Hold during write: finish, one idle state, then hold with ack.
// [RL16] Other masters keep hold low around reset for 34 clocks.
// [RL17] Lock driven for acknowledge, exchange, descriptor, prefixed cycles.
// [RL18] Lock stays through series; drops after first command of next-to-last.
// [RL19] Acknowledge cycles drop lock after their first command state.
// [RL20] Prefetch when idle and two queue bytes free; byte fetch at odd.
// [RL21] Prefetch stops once control transfer or halt is decoded.
// [RL22] Protected mode: stop at segment's last word; flag fault 13.
// [RL23] Processor clock is the system clock divided by two.
// [RL24] Every bus state lasts exactly one processor clock.
// [RL25] Address, data, status drivers float during hold.
// [RL26] Idle, status, command, hold; final command goes straight to status.
`timescale 1ns/1ps
`include "lbc_regs.svh"
module lbc_core
  import lbc_pkg::*;
#(
  parameter int FIFO_DEPTH = `LBC_FIFO_DEPTH
) (
  input  logic         clk_sys,
  input  logic         rst_n,
  input  logic         reqValid,
  output logic         reqReady,
  input  lbc_op_type   reqKind,
  input  lbc_lock_type reqLock,
  input  logic [23:0]  reqAddr,
  input  logic [15:0]  reqData,
  output logic         rdValid,
  output logic [15:0]  rdData,
  output logic         rdCode,
  input  logic         holdReq,
  output logic         holdAck,
  input  logic         commandPostponeIn,
  input  logic         syncDoneIn,
  input  logic         asyncDoneIn,
  input  logic         syncDoneSelectN,
  input  logic         asyncDoneSelectN,
  output logic         busReady,
  output logic [1:0]   statusN,
  output logic         statusOe,
  output logic [23:0]  addrOut,
  output logic         addrOe,
  output logic [15:0]  dataOut,
  output logic         dataOe,
  input  logic [15:0]  dataIn,
  output logic         aleOut,
  output logic         commandOut,
  output logic         transceiverEnable,
  output logic         transferDirection,
  output logic         lockN,
  output logic         lockOe,
  input  logic [1:0]   codeTake,
  input  logic         jumpValid,
  input  logic [23:0]  jumpAddr,
  input  logic         ctlDecoded,
  input  logic         haltInstruction,
  input  logic         protMode,
  input  logic [23:0]  segLastAddr,
  input  logic         execPastEnd,
  output logic         fault13
);

  typedef struct packed {
    lbc_bus_type  bus;
    logic         ph;
    lbc_op_type   kind;
    lbc_lock_type lockMode;
    logic         lockAct;
    logic         seqNext;
    logic         lockSeq;
    logic         firstTc;
    logic         cmdOn;
    logic         syncRdy;
    logic         asyncMeta;
    logic         asyncSync;
    logic [23:0]  addr;
    logic [15:0]  wdata;
    logic         dataOe;
    logic [15:0]  dataOut;
    logic         isFetch;
    logic         pfDrop;
    logic         pfStop;
    logic [23:0]  fetchAddr;
    logic [2:0]   qFree;
    logic         rdValid;
    logic [15:0]  rdData;
    logic         rdCode;
    logic         fault13;
  } lbc_state_type;

  lbc_state_type           s;
  lbc_state_type           n;
  logic                    fifoValid;
  logic                    fifoPop;
  logic [`LBC_REQ_W-1:0]   fifoWord;
  logic [`LBC_REQ_W-1:0]   reqWord;
  lbc_op_type              fKind;
  lbc_lock_type            fLock;
  lbc_lock_type            useLock;
  logic                    rdy;
  logic                    atEnd;
  logic                    justWrote;
  logic                    pfWant;
  logic                    pfLimit;
  logic [2:0]              qSub;

  function automatic logic [2:0] fetchBytes(input logic odd);
    fetchBytes = odd ? `LBC_PF_BYTE : `LBC_PF_WORD;
  endfunction

  assign reqWord = {reqKind, reqLock, reqAddr, reqData};
  assign fKind   = lbc_op_type'(fifoWord[43:42]);
  assign fLock   = lbc_lock_type'(fifoWord[41:40]);
  assign useLock = (fKind == OP_INTA) ? LK_DROP : fLock; // RL19
  assign rdy     = s.syncRdy | s.asyncSync; // RL9
  // Whole-word compare: last even byte still takes a word fetch
  assign pfLimit = protMode && (s.fetchAddr[23:1] > segLastAddr[23:1]); // RL22

  lbc_fifo #(.WIDTH(`LBC_REQ_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .inValid  (reqValid),
    .inReady  (reqReady),
    .inData   (reqWord),
    .outValid (fifoValid),
    .outReady (fifoPop),
    .outData  (fifoWord)
  );

  always_comb begin
    n         = s;
    fifoPop   = 1'b0;
    atEnd     = 1'b0;
    justWrote = 1'b0;
    qSub      = 3'h0;
    n.ph      = ~s.ph; // RL23
    n.rdValid = 1'b0;
    n.fault13 = protMode && execPastEnd; // RL22
    // Phase-1 edge decides who drives the data bus in phase 2
    if (!s.ph) begin
      n.dataOe = (s.bus == BUS_TS || s.bus == BUS_TC)
                 && s.kind == OP_WR; // RL12 RL13 RL14
    end
    case (s.bus)
      BUS_TI: begin
        atEnd = s.ph;
      end
      BUS_TS: begin
        if (!s.ph) begin
          n.dataOut = s.wdata; // RL12
        end else begin
          n.bus       = BUS_TC; // RL24
          n.firstTc   = 1'b1;
          // Outside logic keeps this inactive here, so no zero-wait end
          n.asyncMeta = asyncDoneIn & ~asyncDoneSelectN; // RL7 RL8 RL10
        end
      end
      BUS_TC: begin
        if (!s.cmdOn && !commandPostponeIn) begin
          n.cmdOn = 1'b1; // RL2 RL3
        end
        if (!s.ph) begin
          n.syncRdy   = syncDoneIn & ~syncDoneSelectN; // RL6 RL9
          n.asyncSync = s.asyncMeta; // RL7
        end else begin
          n.firstTc = 1'b0;
          if (s.firstTc && s.lockMode == LK_DROP) begin
            n.lockAct = 1'b0; // RL18 RL19
          end
          if (rdy) begin
            atEnd       = 1'b1;
            justWrote   = s.kind == OP_WR;
            n.cmdOn     = 1'b0;
            n.syncRdy   = 1'b0;
            n.asyncSync = 1'b0;
            n.lockSeq   = s.seqNext;
            n.pfDrop    = 1'b0;
            if (s.lockMode != LK_FULL) begin
              n.lockAct = 1'b0; // RL18
            end
            if (s.kind != OP_WR && !s.pfDrop) begin
              n.rdValid = 1'b1;
              n.rdData  = dataIn;
              n.rdCode  = s.isFetch;
            end
            if (s.isFetch && !s.pfDrop) begin
              qSub = fetchBytes(s.addr[0]); // RL20
            end
          end else begin
            n.asyncMeta = asyncDoneIn & ~asyncDoneSelectN; // RL1 RL7
          end
        end
      end
      BUS_TH: begin
        atEnd = s.ph;
      end
      default: begin
        n.bus = BUS_TI;
      end
    endcase

    n.qFree = s.qFree + {1'b0, codeTake} - qSub;
    if (jumpValid) begin
      n.fetchAddr = jumpAddr;
      n.qFree     = `LBC_Q_BYTES;
      n.pfStop    = 1'b0;
      // A fetch in flight belongs to the old stream
      if ((s.bus == BUS_TS || s.bus == BUS_TC) && s.isFetch && !atEnd) begin
        n.pfDrop = 1'b1;
      end
    end
    // Stop beats a jump arriving in the same cycle
    if (ctlDecoded || haltInstruction) begin
      n.pfStop = 1'b1; // RL21
    end
    pfWant = !n.pfStop && !pfLimit && (n.qFree >= `LBC_PF_MIN); // RL20

    if (atEnd) begin
      if (fifoValid && (n.lockSeq || !holdReq)) begin
        n.bus      = BUS_TS; // RL26
        n.kind     = fKind;
        n.lockMode = useLock;
        n.lockAct  = useLock != LK_NONE; // RL17
        n.seqNext  = fLock != LK_NONE;
        n.addr     = fifoWord[39:16];
        n.wdata    = fifoWord[15:0];
        n.isFetch  = 1'b0;
        fifoPop    = 1'b1;
      end else if (holdReq && !n.lockSeq) begin
        // Idle state after a write protects write-data hold
        n.bus     = justWrote ? BUS_TI : BUS_TH; // RL15 RL16
        n.lockSeq = 1'b0;
      end else if (pfWant) begin
        n.bus       = BUS_TS; // RL26
        n.kind      = OP_RD;
        n.lockMode  = LK_NONE;
        n.lockAct   = 1'b0;
        n.seqNext   = 1'b0;
        n.isFetch   = 1'b1;
        n.addr      = n.fetchAddr;
        n.fetchAddr = n.fetchAddr
                      + {21'h0, fetchBytes(n.fetchAddr[0])}; // RL20
      end else begin
        n.bus = BUS_TI; // RL26
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s       <= '0;
      s.qFree <= `LBC_Q_BYTES;
    end else begin
      s <= n;
    end
  end

  assign holdAck    = s.bus == BUS_TH; // RL15
  assign statusOe   = s.bus != BUS_TH; // RL25
  assign addrOe     = s.bus != BUS_TH; // RL25
  assign lockOe     = s.bus != BUS_TH;
  assign addrOut    = s.addr;
  assign dataOut    = s.dataOut;
  assign dataOe     = s.dataOe;
  assign lockN      = ~s.lockAct; // RL17
  assign rdValid    = s.rdValid;
  assign rdData     = s.rdData;
  assign rdCode     = s.rdCode;
  assign fault13    = s.fault13;
  assign busReady   = rdy && s.bus == BUS_TC;
  assign aleOut     = s.bus == BUS_TS && !s.ph; // RL4
  assign commandOut = s.cmdOn && s.bus == BUS_TC; // RL2
  assign transceiverEnable = s.bus == BUS_TC
                             || (s.bus == BUS_TS && s.ph
                                 && s.kind == OP_WR); // RL4
  assign transferDirection = !(s.kind != OP_WR
                               && (s.bus == BUS_TS
                                   || s.bus == BUS_TC)); // RL11 RL4
  assign statusN = (s.bus != BUS_TS)  ? `LBC_ST_IDLE : // RL5
                   (s.kind == OP_WR)  ? `LBC_ST_WRITE :
                   (s.kind == OP_RD)  ? `LBC_ST_READ : `LBC_ST_INTA;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence sEnd;
    s.bus == BUS_TC && s.ph && rdy;
  endsequence

  sequence sWrStart;
    s.bus == BUS_TS && !s.ph && s.kind == OP_WR;
  endsequence

  phaseFlip_a: assert property ($past(rst_n) |-> s.ph != $past(s.ph)) // RL23
    else $error("phase did not alternate");
  stateLen_a: assert property ((s.bus != $past(s.bus))
      |-> (!s.ph && $past(s.ph))) // RL24
    else $error("bus state changed mid processor clock");
  waitRepeat_a: assert property ((s.bus == BUS_TC && s.ph && !rdy)
      |=> (s.bus == BUS_TC && !s.ph)) // RL1
    else $error("command state not repeated without ready");
  statusIdle_a: assert property ((s.bus != BUS_TS)
      |-> (statusN == `LBC_ST_IDLE)) // RL5
    else $error("status active outside status state");
  cmdStart_a: assert property ((s.bus == BUS_TC && !s.ph
      && !commandPostponeIn) |=> commandOut) // RL2
    else $error("command not activated after postpone low");
  cmdStay_a: assert property ((commandOut && !s.ph)
      |=> commandOut) // RL3
    else $error("command dropped within the cycle");
  aleFixed_a: assert property ((s.bus == BUS_TS && !s.ph)
      |-> aleOut ##1 !aleOut) // RL4
    else $error("latch enable timing moved");
  syncMask_a: assert property ((s.bus == BUS_TC && !s.ph
      && syncDoneSelectN && !s.asyncMeta) |=> !busReady) // RL9 RL6
    else $error("deselected sync done reached ready");
  asyncLag_a: assert property ((s.bus == BUS_TC && s.ph && !rdy // RL7
      && asyncDoneIn && !asyncDoneSelectN) |=> !busReady ##1 busReady)
    else $error("async done not resolved after one clock");
  dirRead_a: assert property ((s.bus == BUS_TC)
      |-> (transferDirection == (s.kind == OP_WR))) // RL11
    else $error("direction wrong in command state");
  wrLate_a: assert property (sWrStart
      |=> dataOe && dataOut == $past(s.wdata)) // RL12
    else $error("write data not driven in phase 2 of status");
  wrHold_a: assert property ((sEnd and s.kind == OP_WR) |=> dataOe
      ##1 (!dataOe || (s.bus == BUS_TS && s.kind == OP_WR))) // RL13 RL14
    else $error("write data hold or float wrong");
  holdGap_a: assert property ((sEnd and s.kind == OP_WR && holdReq
      && !s.seqNext) |=> (s.bus == BUS_TI) [*2] ##1 holdAck) // RL15
    else $error("no single idle state before hold");
  holdFloat_a: assert property (holdAck
      |-> !addrOe && !statusOe && !dataOe) // RL25
    else $error("drivers active during hold");
  lockDrop_a: assert property ((s.bus == BUS_TC && s.ph && s.firstTc
      && s.lockMode == LK_DROP) |=> lockN) // RL18 RL19
    else $error("lock not dropped after first command state");
  pfRoom_a: assert property ((s.bus == BUS_TS && s.isFetch)
      |-> s.qFree >= `LBC_PF_MIN) // RL20
    else $error("prefetch with under two bytes free");
endmodule

// *** hw/lbc_regs.svh ***
// Purpose: constants of the local bus cycle sequencer
// Assumes: included by bare name from the design files
// Notes:   status codes are active low on the pins
`ifndef LBC_REGS_SVH
`define LBC_REGS_SVH

`define LBC_ST_IDLE    2'h3
`define LBC_ST_READ    2'h2
`define LBC_ST_WRITE   2'h1
`define LBC_ST_INTA    2'h0

`define LBC_Q_BYTES    3'h6
`define LBC_PF_MIN     3'h2
`define LBC_PF_BYTE    3'h1
`define LBC_PF_WORD    3'h2

`define LBC_FIFO_DEPTH 32
`define LBC_REQ_W      44

`endif

// *** hw/lbc_pkg.sv ***
// Purpose: types of the local bus cycle sequencer
// Assumes: nothing
// Notes:   bus states each last one processor clock
package lbc_pkg;

  typedef enum logic [1:0] {
    BUS_TI = 2'b00,
    BUS_TS = 2'b01,
    BUS_TC = 2'b10,
    BUS_TH = 2'b11
  } lbc_bus_type;

  typedef enum logic [1:0] {
    OP_RD   = 2'b00,
    OP_WR   = 2'b01,
    OP_INTA = 2'b10
  } lbc_op_type;

  typedef enum logic [1:0] {
    LK_NONE = 2'b00,
    LK_FULL = 2'b01,
    LK_DROP = 2'b10
  } lbc_lock_type;

endpackage

// *** hw/lbc_mem.sv ***
// Purpose: small memory with registered read data
// Assumes: one write and one read port, same clock
// Notes:   read of an address written the same edge returns old data
`timescale 1ns/1ps
module lbc_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input  logic                     clk_sys,
  input  logic                     rst_n,
  input  logic                     wrEn,
  input  logic [$clog2(DEPTH)-1:0] wrAddr,
  input  logic [WIDTH-1:0]         wrData,
  input  logic [$clog2(DEPTH)-1:0] rdAddr,
  output logic [WIDTH-1:0]         rdData
);
  logic [WIDTH-1:0] store [DEPTH];

  always_ff @(posedge clk_sys) begin
    if (wrEn) begin
      store[wrAddr] <= wrData;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rdData <= '0;
    end else begin
      rdData <= store[rdAddr];
    end
  end
endmodule

// *** hw/lbc_fifo.sv ***
// Purpose: request FIFO with valid/ready on both sides
// Assumes: DEPTH is a power of two
// Notes:   a word written into an empty FIFO shows two edges later
`timescale 1ns/1ps
module lbc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input  logic             clk_sys,
  input  logic             rst_n,
  input  logic             inValid,
  output logic             inReady,
  input  logic [WIDTH-1:0] inData,
  output logic             outValid,
  input  logic             outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wrPtr;
    logic [AW-1:0] rdPtr;
    logic [AW:0]   count;
    logic          hazard;
  } lbc_fifo_type;

  lbc_fifo_type  s;
  lbc_fifo_type  n;
  logic          push;
  logic          pop;
  logic [AW-1:0] rdNext;

  assign inReady  = s.count != FULL_CNT;
  // Memory read lags a write by one edge
  assign outValid = (s.count != '0) && !s.hazard;
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;
  assign rdNext   = pop ? s.rdPtr + 1'b1 : s.rdPtr;

  always_comb begin
    n = s;
    if (push) begin
      n.wrPtr = s.wrPtr + 1'b1;
    end
    n.rdPtr  = rdNext;
    n.hazard = push && (s.wrPtr == rdNext);
    case ({push, pop})
      2'b10:   n.count = s.count + 1'b1;
      2'b01:   n.count = s.count - 1'b1;
      default: n.count = s.count;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  lbc_mem #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_mem (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .wrEn    (push),
    .wrAddr  (s.wrPtr),
    .wrData  (inData),
    .rdAddr  (rdNext),
    .rdData  (outData)
  );
endmodule

// *** verification/lbc_far_model.sv ***
// Purpose: far side of the local bus: ready sources, postpone, read data
// Assumes: each bus operation is framed by the address latch pulse
// Notes:   released data lines toggle every cycle instead of holding
`timescale 1ns/1ps
`include "lbc_regs.svh"
module lbc_far_model (
  input  logic        clk_sys,
  input  logic        rst_n,
  input  logic        aleOut,
  input  logic [23:0] addrOut,
  input  logic [1:0]  statusN,
  input  logic [3:0]  waitCnt,
  input  logic [3:0]  postponeCnt,
  input  logic        useAsync,
  output logic        syncDoneIn,
  output logic        asyncDoneIn,
  output logic        commandPostponeIn,
  output logic [15:0] dataIn
);
  logic [4:0]  cnt_q;
  logic [23:0] addr_q;
  logic        read_q;
  logic [15:0] junk_q;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cnt_q  <= 5'h1F;
      addr_q <= 24'h000000;
      read_q <= 1'b0;
      junk_q <= 16'h0F0F;
    end else begin
      junk_q <= ~junk_q;
      if (aleOut) begin
        cnt_q  <= 5'h01;
        addr_q <= addrOut;
        read_q <= statusN != `LBC_ST_WRITE;
      end else if (cnt_q != 5'h1F) begin
        cnt_q <= cnt_q + 5'h01;
      end
    end
  end

  // Phase count since status: 2 is the first command phase
  assign syncDoneIn = cnt_q >= {waitCnt, 1'b0} + 5'h02;
  // Low at the end of status unless waitCnt is zero, so async needs a wait
  assign asyncDoneIn = useAsync && cnt_q >= {waitCnt, 1'b0};
  // Late pulse after command start probes that it is ignored
  assign commandPostponeIn = (cnt_q < {1'b0, postponeCnt} + 5'h01) ||
                             (cnt_q == {1'b0, postponeCnt} + 5'h03);
  assign dataIn = (read_q && cnt_q >= 5'h02 &&
                   cnt_q <= {waitCnt, 1'b0} + 5'h03) ?
                  addr_q[15:0] ^ 16'h5A3C : junk_q;
endmodule

// *** verification/tb_local_bus_cycle_control.sv ***
// Purpose: self-checking bench of the local bus cycle sequencer
// Assumes: prefetch queue is not consumed unless a scenario takes bytes
// Notes:   cycle figures count clk_sys phases from the latch pulse
`timescale 1ns/1ps
`include "lbc_regs.svh"
`define CHK(nm, ex, got) begin total_checks++; \
  if ((got) !== (ex)) begin failures++; \
  $display("MISMATCH %s exp %0h got %0h", nm, ex, got); end end
module tb_local_bus_cycle_control
  import lbc_pkg::*;
;
  logic         clk_sys, rst_n, reqValid, reqReady, rdValid, rdCode;
  logic         holdReq, holdAck, commandPostponeIn, syncDoneIn, asyncDoneIn;
  logic         syncDoneSelectN, asyncDoneSelectN, busReady, statusOe;
  logic         addrOe, dataOe, aleOut, commandOut, transceiverEnable;
  logic         transferDirection, lockN, lockOe, jumpValid, ctlDecoded;
  logic         haltInstruction, protMode, execPastEnd, fault13, useAsync;
  lbc_op_type   reqKind;
  lbc_lock_type reqLock;
  logic [23:0]  reqAddr, addrOut, jumpAddr, segLastAddr;
  logic [15:0]  reqData, rdData, dataOut, dataIn;
  logic [1:0]   statusN, codeTake;
  logic [3:0]   waitCnt, postponeCnt;
  int           cyc, failures, total_checks;

  lbc_core #(.FIFO_DEPTH(`LBC_FIFO_DEPTH)) i_dut (
    .clk_sys, .rst_n, .reqValid, .reqReady, .reqKind, .reqLock, .reqAddr,
    .reqData, .rdValid, .rdData, .rdCode, .holdReq, .holdAck,
    .commandPostponeIn, .syncDoneIn, .asyncDoneIn, .syncDoneSelectN,
    .asyncDoneSelectN, .busReady, .statusN, .statusOe, .addrOut, .addrOe,
    .dataOut, .dataOe, .dataIn, .aleOut, .commandOut, .transceiverEnable,
    .transferDirection, .lockN, .lockOe, .codeTake, .jumpValid, .jumpAddr,
    .ctlDecoded, .haltInstruction, .protMode, .segLastAddr, .execPastEnd,
    .fault13);

  lbc_far_model i_far (.clk_sys, .rst_n, .aleOut, .addrOut, .statusN,
    .waitCnt, .postponeCnt, .useAsync, .syncDoneIn, .asyncDoneIn,
    .commandPostponeIn, .dataIn);

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) cyc <= cyc + 1;

  task automatic step(int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  function automatic logic pick(int w);
    case (w)
      0: return aleOut;
      1: return rdValid;
      2: return holdAck;
      3: return commandOut;
      default: return !holdAck;
    endcase
  endfunction

  task automatic waitFor(int w, output int t);
    int n;
    n = 0;
    step(1);
    while (pick(w) !== 1'b1 && n < 400) begin
      step(1);
      n++;
    end
    `CHK("wait", 1'b1, pick(w))
    t = cyc;
  endtask

  // Leaves the request raised so back-to-back pushes never glitch it
  task automatic push(lbc_op_type k, lbc_lock_type l, logic [23:0] a);
    reqValid = 1'b1;
    reqKind = k;
    reqLock = l;
    reqAddr = a;
    reqData = a[15:0] ^ 16'h1234;
    `CHK("req_rdy", 1'b1, reqReady)
    step(1);
  endtask

  task automatic rd(logic [23:0] a, int len);
    int t0, t1;
    push(OP_RD, LK_NONE, a);
    reqValid = 1'b0;
    waitFor(0, t0);
    `CHK("addr", a, addrOut)
    `CHK("status", `LBC_ST_READ, statusN)
    `CHK("dir_rd", 1'b0, transferDirection)
    step(2);
    `CHK("stat_idle", `LBC_ST_IDLE, statusN)
    waitFor(1, t1);
    `CHK("len", len, t1 - t0)
    `CHK("rdata", a[15:0] ^ 16'h5A3C, rdData)
    `CHK("code", 1'b0, rdCode)
  endtask

  task automatic wr(int n);
    int t0, run;
    for (int i = 0; i < n; i++) push(OP_WR, LK_NONE, 24'h000200 + 24'(2 * i));
    reqValid = 1'b0;
    waitFor(0, t0);
    `CHK("oe_ts1", 1'b0, dataOe)
    step(1);
    `CHK("wdata", 16'h0200 ^ 16'h1234, dataOut)
    run = 0;
    while (dataOe === 1'b1 && run < 40) begin
      `CHK("dir_wr", 1'b1, transferDirection)
      run++;
      step(1);
    end
    `CHK("oe_run", 4 * n, run)
  endtask

  task automatic count(int cy, output int n, output logic [23:0] a);
    n = 0;
    a = 24'h000000;
    repeat (cy) begin
      if (aleOut === 1'b1) begin
        if (n == 0) a = addrOut;
        n++;
      end
      if (rdValid === 1'b1) `CHK("pf_code", 1'b1, rdCode)
      step(1);
    end
  endtask

  task automatic t_sync;
    rd(24'h000010, 4);
    waitCnt = 4'h2;
    rd(24'h000012, 8);
    waitCnt = 4'h0;
  endtask

  task automatic t_async;
    // Sync source stays active but deselected, so only async may end
    syncDoneSelectN = 1'b1;
    asyncDoneSelectN = 1'b0;
    useAsync = 1'b1;
    waitCnt = 4'h1;
    rd(24'h000020, 6);
    waitCnt = 4'h2;
    rd(24'h000022, 8);
    syncDoneSelectN = 1'b0;
    asyncDoneSelectN = 1'b1;
    useAsync = 1'b0;
    waitCnt = 4'h0;
  endtask

  task automatic t_postpone;
    int t0, t1;
    waitCnt = 4'h2;
    postponeCnt = 4'h2;
    push(OP_RD, LK_NONE, 24'h000040);
    reqValid = 1'b0;
    waitFor(0, t0);
    step(2);
    `CHK("den", 1'b1, transceiverEnable)
    `CHK("cmd_held", 1'b0, commandOut)
    waitFor(3, t1);
    `CHK("cmd_at", 4, t1 - t0)
    step(2);
    `CHK("cmd_kept", 1'b1, commandOut)
    `CHK("rdy_wait", 1'b0, busReady)
    step(1);
    `CHK("bus_rdy", 1'b1, busReady)
    waitFor(1, t1);
    `CHK("len_pp", 8, t1 - t0)
    postponeCnt = 4'h0;
    waitCnt = 4'h0;
  endtask

  task automatic t_hold;
    int t0, t1;
    push(OP_WR, LK_NONE, 24'h000300);
    reqValid = 1'b0;
    waitFor(0, t0);
    holdReq = 1'b1;
    waitFor(2, t1);
    `CHK("hold_at", 6, t1 - t0)
    `CHK("addr_oe", 1'b0, addrOe)
    `CHK("stat_oe", 1'b0, statusOe)
    `CHK("data_oe", 1'b0, dataOe)
    `CHK("lock_oe", 1'b0, lockOe)
    holdReq = 1'b0;
    waitFor(4, t1);
  endtask

  task automatic t_lock;
    int t;
    waitCnt = 4'h1;
    // Park in hold so the whole series is queued before it starts
    holdReq = 1'b1;
    waitFor(2, t);
    push(OP_RD, LK_FULL, 24'h000500);
    push(OP_RD, LK_DROP, 24'h000502);
    push(OP_RD, LK_NONE, 24'h000504);
    reqValid = 1'b0;
    holdReq = 1'b0;
    waitFor(0, t);
    `CHK("lk_first", 1'b0, lockN)
    waitFor(0, t);
    `CHK("lk_ntl", 1'b0, lockN)
    step(3);
    `CHK("lk_keep", 1'b0, lockN)
    step(1);
    `CHK("lk_drop", 1'b1, lockN)
    waitFor(0, t);
    `CHK("lk_last", 1'b1, lockN)
    push(OP_INTA, LK_NONE, 24'h000000);
    reqValid = 1'b0;
    waitFor(0, t);
    `CHK("lk_ack", 1'b0, lockN)
    step(3);
    `CHK("lk_ack_keep", 1'b0, lockN)
    step(1);
    `CHK("lk_ack_drop", 1'b1, lockN)
    waitFor(1, t);
    waitCnt = 4'h0;
  endtask

  task automatic t_fill;
    int n, t;
    holdReq = 1'b1;
    waitFor(2, t);
    waitCnt = 4'h2;
    reqValid = 1'b1;
    reqKind = OP_RD;
    reqLock = LK_NONE;
    reqAddr = 24'h000600;
    n = 0;
    while (reqReady === 1'b1 && n < 40) begin
      step(1);
      n++;
    end
    reqValid = 1'b0;
    `CHK("fifo_cap", `LBC_FIFO_DEPTH, n)
    holdReq = 1'b0;
    n = 0;
    repeat (400) begin
      step(1);
      if (rdValid === 1'b1) n++;
    end
    `CHK("drained", `LBC_FIFO_DEPTH, n)
    `CHK("empty_rdy", 1'b1, reqReady)
    waitCnt = 4'h0;
  endtask

  task automatic t_prefetch;
    int n;
    logic [23:0] a;
    jumpAddr = 24'h000101;
    jumpValid = 1'b1;
    step(1);
    jumpValid = 1'b0;
    count(60, n, a);
    `CHK("pf_odd", 24'h000101, a)
    `CHK("pf_cnt", 3, n)
    haltInstruction = 1'b1;
    step(1);
    haltInstruction = 1'b0;
    codeTake = 2'h2;
    step(2);
    codeTake = 2'h0;
    count(40, n, a);
    `CHK("pf_stop", 0, n)
    protMode = 1'b1;
    segLastAddr = 24'h000103;
    jumpValid = 1'b1;
    step(1);
    jumpValid = 1'b0;
    count(60, n, a);
    `CHK("pf_seg", 2, n)
    execPastEnd = 1'b1;
    step(1);
    execPastEnd = 1'b0;
    `CHK("f13", 1'b1, fault13)
    protMode = 1'b0;
    execPastEnd = 1'b1;
    step(1);
    execPastEnd = 1'b0;
    `CHK("f13_real", 1'b0, fault13)
  endtask

  task automatic test_done;
    if (failures == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (6000) @(posedge clk_sys);
    failures++;
    test_done;
  end

  initial begin
    {failures, total_checks} = '0;
    {rst_n, reqValid, holdReq, jumpValid, haltInstruction} = '0;
    {useAsync, protMode, execPastEnd, ctlDecoded} = '0;
    {syncDoneSelectN, asyncDoneSelectN} = 2'h1;
    reqKind = OP_RD;
    reqLock = LK_NONE;
    {reqAddr, reqData, jumpAddr} = '0;
    segLastAddr = 24'hFFFFFF;
    {codeTake, waitCnt, postponeCnt} = '0;
    step(20);
    rst_n = 1'b1;
    // Hold request stays low well past the post-reset window
    step(40);
    ctlDecoded = 1'b1;
    step(1);
    ctlDecoded = 1'b0;
    step(10);
    t_sync;
    t_async;
    wr(1);
    wr(2);
    t_postpone;
    t_hold;
    t_lock;
    t_fill;
    t_prefetch;
    test_done;
  end
endmodule
